/* hdl/adc_serial_config_port.sv */
`timescale 1ns/100ps
// Overview of operation
// - a frame runs from chip select falling to chip select rising
// - enough clock falling edges in a frame commit its write at chip select rise
// - 32-clock mode needs 32 edges dual-lane, 48 single-lane
// - 16-clock mode needs 16 edges dual-lane, 32 single-lane
// - too few edges before chip select rises: no register changes
// - first 16 input bits captured msb first; settings apply only when validated
// - top four captured bits pick operation, target and meaning of the rest
// - opcodes 1, 2, 3 request readback of level A, level B, configuration
// - opcodes 8, 9, A write configuration, level A, level B
// - opcodes 0, B and any with bit 14 set do nothing
// - configuration written in a frame steers the following frame
// - configuration word clears to zero at power-up
// - bit 11 picks 16-clock mode; fixed-32 variant ignores it
// - bit 10 picks single output lane A instead of two lanes
// - bit 9 picks doubled input span
// - bit 6 picks internal reference, zero picks external
// - bit 5 is write-only standby enter or leave control
// - level write takes captured bits 11 to 3; low three bits read zero
// - frame after readback request shifts register out on lane A, lane B zero
module adc_serial_config_port #(
	parameter bit FIXED_32CLK = 1'b0
) (
	// clock and reset
	input  wire logic                           mclk,
	input  wire logic                           rstn,
	// serial pins from the host
	input  wire logic                           cs_n,
	input  wire logic                           sclk,
	input  wire logic                           sdi,
	// serial data pins to the host
	output logic                                serial_out_lane_a,
	output logic                                serial_out_lane_b,
	// settings seen by the converter core for the current frame
	output cfg_port_pkg::cfg_out_t              cfg_out,
	output logic [cfg_port_pkg::REF_W-1:0]      ref_level_chan_a,
	output logic [cfg_port_pkg::REF_W-1:0]      ref_level_chan_b,
	// frame status
	output logic                                frame_active,
	output logic                                frame_valid,
	output logic                                frame_invalid
);
	import cfg_port_pkg::*;

	logic [PIN_W-1:0]  pin_lvl;
	logic [PIN_W-1:0]  pin_rise;
	logic [PIN_W-1:0]  pin_fall;
	state_t            s_q;
	state_t            s_d;
	logic [3:0]        op;
	logic [CMD_W-1:0]  rd_word;
	logic [CNT_W-1:0]  need_next;
	cfg_out_t          cfg_next;

	// the serial clock is sampled, not used as a clock: 16 samples per bit at the bench rate
	pin_sync #(
		.W(PIN_W)
	) u_pin_sync (
		.mclk      (mclk),
		.rstn      (rstn),
		.pin_async ({cs_n, sclk, sdi}),
		.level     (pin_lvl),
		.rise      (pin_rise),
		.fall      (pin_fall)
	);

	assign op = s_q.cmd[OP_MSB:OP_LSB];

	// word to be shifted out in the frame after a readback request
	always_comb begin
		case (s_q.rd_pend)
			RD_REFA: rd_word = {4'h0, s_q.ref_a, 3'h0};
			RD_REFB: rd_word = {4'h0, s_q.ref_b, 3'h0};
			RD_CFG:  rd_word = {4'h0, s_q.cfg & CFG_RD_MASK};
			default: rd_word = 16'h0000;
		endcase
	end

	// settings taken at frame start, so a write lands one frame later
	always_comb begin
		cfg_next.sixteen_clk_mode   = s_q.cfg[CFG_CLK_MODE] & ~FIXED_32CLK;
		cfg_next.output_lane_select = s_q.cfg[CFG_LANES];
		cfg_next.double_range       = s_q.cfg[CFG_RANGE];
		cfg_next.internal_ref       = s_q.cfg[CFG_REF_SEL];
		cfg_next.standby_req        = s_q.cfg[CFG_STANDBY];
		case ({cfg_next.sixteen_clk_mode, cfg_next.output_lane_select})
			2'b00:   need_next = N_32_DUAL;
			2'b01:   need_next = N_32_SINGLE;
			2'b10:   need_next = N_16_DUAL;
			2'b11:   need_next = N_16_SINGLE;
			default: need_next = N_32_DUAL;
		endcase
	end

	always_comb begin
		s_d           = s_q;
		s_d.valid_p   = 1'b0;
		s_d.invalid_p = 1'b0;
		s_d.lane_b    = 1'b0;
		case (s_q.st)
			ST_IDLE: begin
				s_d.lane_a = 1'b0;
				if (pin_fall[PIN_CS]) begin
					s_d.st      = ST_FRAME;
					s_d.falls   = 6'h00;
					s_d.cmd     = 16'h0000;
					s_d.cfg_o   = cfg_next;
					s_d.need    = need_next;
					s_d.shout   = rd_word;
					s_d.lane_a  = rd_word[CMD_W-1];
					s_d.rd_pend = RD_NONE;
				end
			end
			ST_FRAME: begin
				if (pin_rise[PIN_CS]) begin
					// a clock fall in the same cycle as the rise is not counted
					s_d.st     = ST_IDLE;
					s_d.lane_a = 1'b0;
					if (s_q.falls >= s_q.need) begin
						s_d.valid_p = 1'b1;
						case (op)
							OP_RD_REFA: s_d.rd_pend = RD_REFA;
							OP_RD_REFB: s_d.rd_pend = RD_REFB;
							OP_RD_CFG:  s_d.rd_pend = RD_CFG;
							OP_WR_CFG:  s_d.cfg = s_q.cmd[DATA_W-1:0] & CFG_KEEP;
							OP_WR_REFA: s_d.ref_a = s_q.cmd[REF_MSB:REF_LSB];
							OP_WR_REFB: s_d.ref_b = s_q.cmd[REF_MSB:REF_LSB];
							default:    s_d.rd_pend = RD_NONE;
						endcase
					end else begin
						s_d.invalid_p = 1'b1;
					end
				end else if (pin_fall[PIN_SCLK]) begin
					if (s_q.falls != CNT_MAX) begin
						s_d.falls = s_q.falls + CNT_ONE;
					end
					if (s_q.falls < CAPTURE_N) begin
						s_d.cmd = {s_q.cmd[CMD_W-2:0], pin_lvl[PIN_SDI]};
					end
					s_d.shout  = {s_q.shout[CMD_W-2:0], 1'b0};
					s_d.lane_a = s_q.shout[CMD_W-2];
				end
			end
			default: begin
				s_d = STATE_RST;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_q <= STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign serial_out_lane_a = s_q.lane_a;
	assign serial_out_lane_b = s_q.lane_b;
	assign cfg_out           = s_q.cfg_o;
	assign ref_level_chan_a  = s_q.ref_a;
	assign ref_level_chan_b  = s_q.ref_b;
	assign frame_active      = s_q.st;
	assign frame_valid       = s_q.valid_p;
	assign frame_invalid     = s_q.invalid_p;

endmodule : adc_serial_config_port

/* hdl/cfg_port_pkg.sv */
package cfg_port_pkg;

	// command word layout
	localparam int          CMD_W        = 16;
	localparam int          OP_MSB       = 15;
	localparam int          OP_LSB       = 12;
	localparam int          DATA_W       = 12;
	localparam int          CNT_W        = 6;
	localparam int          REF_W        = 9;
	localparam int          REF_MSB      = 11;
	localparam int          REF_LSB      = 3;

	// opcodes in the top four bits of the command word
	localparam logic [3:0]  OP_NOP       = 4'h0;
	localparam logic [3:0]  OP_RD_REFA   = 4'h1;
	localparam logic [3:0]  OP_RD_REFB   = 4'h2;
	localparam logic [3:0]  OP_RD_CFG    = 4'h3;
	localparam logic [3:0]  OP_WR_CFG    = 4'h8;
	localparam logic [3:0]  OP_WR_REFA   = 4'h9;
	localparam logic [3:0]  OP_WR_REFB   = 4'hA;

	// configuration word bit positions
	localparam int          CFG_CLK_MODE = 11;
	localparam int          CFG_LANES    = 10;
	localparam int          CFG_RANGE    = 9;
	localparam int          CFG_REF_SEL  = 6;
	localparam int          CFG_STANDBY  = 5;

	// only defined bits are kept; standby does not read back
	localparam logic [11:0] CFG_KEEP     = 12'hE60;
	localparam logic [11:0] CFG_RD_MASK  = 12'hE40;
	localparam logic [11:0] CFG_RESET    = 12'h000;
	localparam logic [8:0]  REF_RESET    = 9'h1FF;

	// falling-edge counts that validate a frame
	localparam logic [5:0]  N_32_DUAL    = 6'h20;
	localparam logic [5:0]  N_32_SINGLE  = 6'h30;
	localparam logic [5:0]  N_16_DUAL    = 6'h10;
	localparam logic [5:0]  N_16_SINGLE  = 6'h20;
	localparam logic [5:0]  CAPTURE_N    = 6'h10;
	localparam logic [5:0]  CNT_MAX      = 6'h3F;
	localparam logic [5:0]  CNT_ONE      = 6'h01;

	// pin bit positions into the synchroniser
	localparam int          PIN_W        = 3;
	localparam int          PIN_CS       = 2;
	localparam int          PIN_SCLK     = 1;
	localparam int          PIN_SDI      = 0;

	typedef enum logic [0:0] {
		ST_IDLE  = 1'b0,
		ST_FRAME = 1'b1
	} frame_state_t;

	typedef enum logic [1:0] {
		RD_NONE = 2'b00,
		RD_REFA = 2'b01,
		RD_REFB = 2'b10,
		RD_CFG  = 2'b11
	} rd_sel_t;

	typedef struct packed {
		logic sixteen_clk_mode;
		logic output_lane_select;
		logic double_range;
		logic internal_ref;
		logic standby_req;
	} cfg_out_t;

	typedef struct packed {
		frame_state_t           st;
		logic [CNT_W-1:0]       falls;
		logic [CMD_W-1:0]       cmd;
		logic [CMD_W-1:0]       shout;
		logic [DATA_W-1:0]      cfg;
		logic [REF_W-1:0]       ref_a;
		logic [REF_W-1:0]       ref_b;
		rd_sel_t                rd_pend;
		cfg_out_t               cfg_o;
		logic [CNT_W-1:0]       need;
		logic                   lane_a;
		logic                   lane_b;
		logic                   valid_p;
		logic                   invalid_p;
	} state_t;

	localparam state_t STATE_RST = '{
		st:        ST_IDLE,
		falls:     6'h00,
		cmd:       16'h0000,
		shout:     16'h0000,
		cfg:       CFG_RESET,
		ref_a:     REF_RESET,
		ref_b:     REF_RESET,
		rd_pend:   RD_NONE,
		cfg_o:     5'h00,
		need:      N_32_DUAL,
		lane_a:    1'b0,
		lane_b:    1'b0,
		valid_p:   1'b0,
		invalid_p: 1'b0
	};

endpackage : cfg_port_pkg

/* hdl/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 3
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rstn,
	// asynchronous pins
	input  wire logic [W-1:0] pin_async,
	// synchronised level and edge pulses
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.meta = pin_async;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// edges look only at the second stage and the one after it
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_edge
			assign level[i] = s_q.sync[i];
			assign rise[i]  = s_q.sync[i] & ~s_q.prev[i];
			assign fall[i]  = ~s_q.sync[i] & s_q.prev[i];
		end
	endgenerate

endmodule : pin_sync

/* dv/adc_serial_config_port_properties.sv */
`timescale 1ns/100ps
module adc_port_checker (
	// clock and reset
	input wire logic                              mclk,
	input wire logic                              rstn,
	// observed outputs
	input wire logic                              serial_out_lane_a,
	input wire logic                              serial_out_lane_b,
	input wire cfg_port_pkg::cfg_out_t            cfg_out,
	input wire logic [cfg_port_pkg::REF_W-1:0]    ref_level_chan_a,
	input wire logic [cfg_port_pkg::REF_W-1:0]    ref_level_chan_b,
	input wire logic                              frame_active,
	input wire logic                              frame_valid,
	input wire logic                              frame_invalid
);
	import cfg_port_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	property p_valid_pulse; frame_valid |=> !frame_valid; endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("valid pulse too long");
	property p_one_verdict; !(frame_valid && frame_invalid); endproperty
	a_one_verdict: assert property (p_one_verdict) else $error("valid and invalid together");
	property p_refa_commit; $changed(ref_level_chan_a) |-> frame_valid; endproperty
	a_refa_commit: assert property (p_refa_commit) else $error("level a changed outside commit");
	property p_refb_commit; $changed(ref_level_chan_b) |-> frame_valid; endproperty
	a_refb_commit: assert property (p_refb_commit) else $error("level b changed outside commit");
	property p_lane_b_zero; !serial_out_lane_b; endproperty
	a_lane_b_zero: assert property (p_lane_b_zero) else $error("lane b not zero");
	property p_cfg_at_start; $changed(cfg_out) |-> ##[0:1] frame_active; endproperty
	a_cfg_at_start: assert property (p_cfg_at_start) else $error("settings changed outside frame start");
	property p_end_verdict; $fell(frame_active) |-> ##[0:1] (frame_valid || frame_invalid); endproperty
	a_end_verdict: assert property (p_end_verdict) else $error("frame ended without verdict");
	property p_idle_lane_a; !frame_active && !$past(frame_active) |-> !serial_out_lane_a; endproperty
	a_idle_lane_a: assert property (p_idle_lane_a) else $error("lane a high while idle");
endmodule : adc_port_checker
bind adc_serial_config_port adc_port_checker i_chk (.mclk, .rstn, .serial_out_lane_a, .serial_out_lane_b, .cfg_out,
	.ref_level_chan_a, .ref_level_chan_b, .frame_active, .frame_valid, .frame_invalid);

/* dv/host_model.sv */
`timescale 1ns/100ps
module host_model (
	// clock
	input  wire logic mclk,
	// link to the device
	output logic      cs_n,
	output logic      sclk,
	output logic      sdi,
	input  wire logic lane_a
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		sdi  = 1'b0;
	end
	// eight mclk per half gives the 64 ns link clock
	task automatic send(input logic [15:0] w, input int n, output logic [15:0] rd);
		rd = 16'h0000;
		@(posedge mclk) cs_n <= 1'b0;
		repeat (8) @(posedge mclk);
		for (int i = 0; i < n; i++) begin
			// junk after bit 16 only where the command is not all zero
			sdi  <= (i < 16) ? w[15 - i] : ((w != 16'h0000) && i[0]);
			sclk <= 1'b1;
			repeat (7) @(posedge mclk);
			@(negedge mclk);
			if (i < 16) rd[15 - i] = lane_a;
			@(posedge mclk) sclk <= 1'b0;
			repeat (8) @(posedge mclk);
		end
		cs_n <= 1'b1;
		sdi  <= 1'b0;
		sclk <= 1'b1;
		repeat (12) @(posedge mclk);
	endtask : send
endmodule : host_model

/* dv/test_adc_serial_config_port.sv */
`timescale 1ns/100ps
module test_adc_serial_config_port;
	import cfg_port_pkg::*;
	logic             mclk, rstn, cs_n, sclk, sdi, lane_a, lane_b, fa, fv, fi;
	cfg_out_t         cfg_out;
	logic [REF_W-1:0] lvl_a, lvl_b, ea, eb;
	logic [11:0]      cfg_e;
	logic [15:0]      w, rd, rd_e;
	logic [31:0]      seed;
	logic [3:0]       op;
	int               n;
	int               n_errors    = 0;
	int               checks_done = 0;
	int               n_valid     = 0;
	int               n_short     = 0;
	int               e_valid     = 0;
	int               e_short     = 0;
	int               n_lane_b    = 0;

	adc_serial_config_port i_dut (.mclk, .rstn, .cs_n, .sclk, .sdi, .serial_out_lane_a(lane_a),
		.serial_out_lane_b(lane_b), .cfg_out, .ref_level_chan_a(lvl_a), .ref_level_chan_b(lvl_b),
		.frame_active(fa), .frame_valid(fv), .frame_invalid(fi));
	host_model i_host (.mclk, .cs_n, .sclk, .sdi, .lane_a);

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	function automatic int need(input logic [11:0] c);
		return c[11] ? (c[10] ? 32 : 16) : (c[10] ? 48 : 32);
	endfunction : need
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	// pulses and lane b are looked at mid-cycle, where they are settled
	always @(negedge mclk) begin
		if (fv === 1'b1) n_valid++;
		if (fi === 1'b1) n_short++;
		if (rstn === 1'b1 && lane_b !== 1'b0) n_lane_b++;
	end

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		#200000;
		n_errors++;
		test_done();
	end
	initial begin
		rstn  = 1'b0;
		seed  = 32'h10;
		cfg_e = 12'h000;
		ea    = 9'h1FF;
		eb    = 9'h1FF;
		rd_e  = 16'h0000;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("cfg_out", 16'h0000, 16'(cfg_out));
		chk("ref_a", 16'h01FF, 16'(lvl_a));
		chk("ref_b", 16'h01FF, 16'(lvl_b));
		// every opcode in turn first, then random ones; frames one short, exact or one long
		for (int k = 0; k < 40; k++) begin
			seed = xs(seed);
			op   = (k < 16) ? k[3:0] : seed[15:12];
			w    = {op, (op == OP_WR_CFG) ? (seed[27:16] & CFG_KEEP) : seed[27:16]};
			if (op inside {OP_RD_REFA, OP_RD_REFB, OP_RD_CFG}) w[11:0] = 12'h000;
			n = need(cfg_e) - 1 + int'(seed[29:28]) % 3;
			// corner cases: every frame-length mode gets a frame one short; all but 16-clock single-lane also get a commit at exactly N
			if (k >= 16 && k < 24) begin
				op = OP_WR_CFG;
				w  = {op, k[2:1], seed[25:16] & 10'h260};
				n  = need(cfg_e) - (k % 2);
			end
			i_host.send(w, n, rd);
			chk("readback", rd_e, rd);
			chk("cfg_out", 16'({cfg_e[11:9], cfg_e[6:5]}), 16'(cfg_out));
			rd_e = 16'h0000;
			if (n >= need(cfg_e)) e_valid++;
			else e_short++;
			if (n >= need(cfg_e)) begin
				case (op)
					OP_RD_REFA: rd_e = {4'h0, ea, 3'h0};
					OP_RD_REFB: rd_e = {4'h0, eb, 3'h0};
					OP_RD_CFG:  rd_e = {4'h0, cfg_e & CFG_RD_MASK};
					OP_WR_CFG:  cfg_e = w[11:0] & CFG_KEEP;
					OP_WR_REFA: ea = w[11:3];
					OP_WR_REFB: eb = w[11:3];
					default:    ;
				endcase
			end
			chk("ref_a", 16'(ea), 16'(lvl_a));
			chk("ref_b", 16'(eb), 16'(lvl_b));
			chk("frame_valid", 16'(e_valid), 16'(n_valid));
			chk("frame_invalid", 16'(e_short), 16'(n_short));
			chk("frame_active", 16'h0000, 16'(fa));
		end
		chk("lane_b", 16'h0000, 16'(n_lane_b));
		test_done();
	end
endmodule : test_adc_serial_config_port
